// [inc/cisc_pkg.sv]
// constants for the cache isolate / swap control block
// assumes one 100 MHz clock, synchronous active-high reset, lane-aligned store data
// What this block does
// - cacheable references are looked up in the cache of their role
// - uncacheable references bypass both caches and go straight to the bus
// - one status bit turns isolation on, another turns swapping on
// - swap makes the data array act as instruction cache and vice versa
// - isolated: stores touch only the data cache, loads always hit there
// - isolated partial-word store clears the valid flag of the addressed line
// - miss flag shows whether the last isolated load missed its tag compare
// - a configuration bit picks one of two cache organizations at run time
// - instruction line is four words sharing one tag and one valid flag
// - size bit clear: 16kB instruction, 4kB data; set: 8kB each
package cisc_pkg;
    // register map on the software port
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] CONFIG_OFS = 8'h04;
    localparam int STAT_ISO_BIT = 0;
    localparam int STAT_SWAP_BIT = 1;
    localparam int STAT_MISS_BIT = 2;
    localparam int CFG_ALT_BIT = 0;
    localparam logic ISO_RST = 1'b0;
    localparam logic SWAP_RST = 1'b0;
    localparam logic MISS_RST = 1'b0;
    localparam logic ALT_RST = 1'b0;
    // virtual segment that never caches
    localparam logic [2:0] SEG_UNCACHED = 3'b101;
    // array geometry: array a is the instruction array, b the data array
    localparam int IARR_IDX_W = 12;
    localparam int DARR_IDX_W = 11;
    localparam int ILINE_BITS = 2;
    localparam int DLINE_BITS = 0;
    // active word masks: i 16kB / 8kB, d 4kB / 8kB
    localparam logic [11:0] IMASK_NORM = 12'hFFF;
    localparam logic [11:0] IMASK_ALT = 12'h7FF;
    localparam logic [10:0] DMASK_NORM = 11'h3FF;
    localparam logic [10:0] DMASK_ALT = 11'h7FF;
    // access sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [3:0] BE_WORD = 4'hF;
    localparam logic [1:0] LINE_LAST_BEAT = 2'h3;
endpackage

// [rtl/cisc_route.sv]
// cacheability and array-role decision for one reference
// assumes virtual address given unchanged; translation lives elsewhere
`timescale 1ns/100ps
module cisc_route (
    input wire logic [31:0] addr,     // reference address
    input wire logic fetch,           // instruction fetch
    input wire logic swap,            // swap mode
    input wire logic alt,             // alternate organization
    output logic cacheable,           // reference may use a cache
    output logic use_iarr,            // reference uses the instruction array
    output logic [11:0] imask,        // active word mask, array a
    output logic [10:0] dmask         // active word mask, array b
);
    always_comb begin
        cacheable = (addr[31:29] != cisc_pkg::SEG_UNCACHED);
        use_iarr = fetch ^ swap;
        imask = alt ? cisc_pkg::IMASK_ALT : cisc_pkg::IMASK_NORM;
        dmask = alt ? cisc_pkg::DMASK_ALT : cisc_pkg::DMASK_NORM;
    end
endmodule

// [rtl/cisc_array.sv]
// one cache array: data words plus one tag and valid per line
// assumes the caller masks nothing; mask comes in as a port
`timescale 1ns/100ps
module cisc_array #(
    parameter int IDX_W = 12,
    parameter int LINE_BITS = 2
) (
    input wire logic clk,                  // clock
    input wire logic sys_rst,              // sync reset, clears valid flags
    input wire logic [IDX_W-1:0] mask,     // active word mask
    input wire logic [29:0] rd_waddr,      // lookup word address
    output logic [31:0] rd_data,           // looked-up word
    output logic rd_hit,                   // line valid and tag equal
    input wire logic wr_en,                // write port enable
    input wire logic [29:0] wr_waddr,      // write word address
    input wire logic [31:0] wr_data,       // write data
    input wire logic [3:0] wr_be,          // byte lanes to write
    input wire logic wr_valid              // new valid flag; tag always loaded
);
    localparam int WORDS = 2 ** IDX_W;
    localparam int LINES = 2 ** (IDX_W - LINE_BITS);
    logic [29-LINE_BITS:0] tag_q [LINES];
    logic [LINES-1:0] valid_q;
    logic [IDX_W-1:0] ridx;
    logic [IDX_W-1:0] widx;
    logic [IDX_W-LINE_BITS-1:0] rline;
    logic [IDX_W-LINE_BITS-1:0] wline;

    always_comb begin
        ridx = rd_waddr[IDX_W-1:0] & mask;
        widx = wr_waddr[IDX_W-1:0] & mask;
        rline = ridx[IDX_W-1:LINE_BITS];
        wline = widx[IDX_W-1:LINE_BITS];
        // one tag and valid per line
        rd_hit = valid_q[rline] && (tag_q[rline] == rd_waddr[29:LINE_BITS]);
    end

    // one store per byte lane, so each lane has a single writer
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            logic [7:0] lane_q [WORDS];
            always_ff @(posedge clk) begin
                if (wr_en && wr_be[b]) begin
                    lane_q[widx] <= wr_data[8*b +: 8];
                end
            end
            assign rd_data[8*b +: 8] = lane_q[ridx];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (wr_en) begin
            tag_q[wline] <= wr_waddr[29:LINE_BITS];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valid_q <= '0;
        end else if (wr_en) begin
            valid_q[wline] <= wr_valid;
        end
    end
endmodule

// [rtl/cisc_ctrl.sv]
// cache isolate / swap control: lookup, bypass, fill, write-through
// assumes core holds a request until core_ready, store data lane-aligned
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module cisc_ctrl (
    input wire logic clk,               // 100 MHz clock
    input wire logic sys_rst,           // sync reset, active high
    // software register port
    input wire logic [7:0] reg_addr,    // register byte address
    input wire logic [31:0] reg_wdata,  // write data
    input wire logic reg_wr,            // write strobe
    input wire logic reg_rd,            // read strobe
    output logic [31:0] reg_rdata,      // read data, cycle after reg_rd
    // execution core
    input wire logic core_req,          // reference request
    input wire logic core_write,        // store when high
    input wire logic core_fetch,        // instruction fetch when high
    input wire logic [1:0] core_size,   // byte, half or word
    input wire logic [31:0] core_addr,  // reference address
    input wire logic [31:0] core_wdata, // store data, lane-aligned
    output logic core_ready,            // request taken this cycle
    output logic core_rsp_valid,        // one-cycle completion pulse
    output logic [31:0] core_rdata,     // load / fetch data
    // bus interface unit
    output logic biu_req,               // bus cycle pending
    output logic biu_write,             // bus write when high
    output logic [31:0] biu_addr,       // bus word address
    output logic [31:0] biu_wdata,      // bus write data
    output logic [3:0] biu_be,          // bus byte lanes
    input wire logic biu_done,          // one beat finished
    input wire logic [31:0] biu_rdata   // read beat data
);
    typedef enum logic [0:0] {ST_IDLE, ST_BUS} cisc_state_t;

    // ==========================================================
    // declarations
    cisc_state_t state_q;
    logic iso_q;
    logic swap_q;
    logic alt_q;
    logic miss_q;
    logic [31:0] reg_rdata_q;
    logic [31:0] r_addr_q;
    logic r_write_q;
    logic [31:0] r_wdata_q;
    logic [3:0] r_be_q;
    logic r_fill_q;
    logic r_line_q;
    logic r_iarr_q;
    logic [1:0] beat_q;
    logic rsp_valid_q;
    logic [31:0] rdata_q;

    logic cacheable;
    logic use_iarr;
    logic [11:0] imask;
    logic [10:0] dmask;
    logic [31:0] i_rd_data;
    logic [31:0] d_rd_data;
    logic i_hit;
    logic d_hit;
    logic [31:0] look_data;
    logic look_hit;
    logic accept;
    logic iso_load;
    logic iso_store;
    logic hit_read;
    logic go_bus;
    logic [3:0] core_be;
    logic last_beat;
    logic want_beat;
    logic w_en;
    logic w_iarr;
    logic [29:0] w_waddr;
    logic [31:0] w_data;
    logic [3:0] w_be;
    logic w_valid;

    // ==========================================================
    // role, cacheability and arrays
    cisc_route u_route (
        .addr(core_addr),
        .fetch(core_fetch),
        .swap(swap_q),
        .alt(alt_q),
        .cacheable(cacheable),
        .use_iarr(use_iarr),
        .imask(imask),
        .dmask(dmask)
    );

    cisc_array #(
        .IDX_W(cisc_pkg::IARR_IDX_W),
        .LINE_BITS(cisc_pkg::ILINE_BITS)
    ) u_iarr (
        .clk(clk),
        .sys_rst(sys_rst),
        .mask(imask),
        .rd_waddr(core_addr[31:2]),
        .rd_data(i_rd_data),
        .rd_hit(i_hit),
        .wr_en(w_en && w_iarr),
        .wr_waddr(w_waddr),
        .wr_data(w_data),
        .wr_be(w_be),
        .wr_valid(w_valid)
    );

    cisc_array #(
        .IDX_W(cisc_pkg::DARR_IDX_W),
        .LINE_BITS(cisc_pkg::DLINE_BITS)
    ) u_darr (
        .clk(clk),
        .sys_rst(sys_rst),
        .mask(dmask),
        .rd_waddr(core_addr[31:2]),
        .rd_data(d_rd_data),
        .rd_hit(d_hit),
        .wr_en(w_en && !w_iarr),
        .wr_waddr(w_waddr),
        .wr_data(w_data),
        .wr_be(w_be),
        .wr_valid(w_valid)
    );

    // ==========================================================
    // request decode
    always_comb begin
        look_data = use_iarr ? i_rd_data : d_rd_data;
        look_hit = use_iarr ? i_hit : d_hit;
        core_ready = (state_q == ST_IDLE);
        accept = core_req && core_ready;
        case (core_size)
            cisc_pkg::SZ_BYTE: core_be = 4'h1 << core_addr[1:0];
            cisc_pkg::SZ_HALF: core_be = core_addr[1] ? 4'hC : 4'h3;
            default: core_be = cisc_pkg::BE_WORD;
        endcase
        // isolated load is a forced hit
        iso_load = cacheable && !core_write && !core_fetch && iso_q;
        // isolated store stays in the cache
        iso_store = cacheable && core_write && iso_q;
        hit_read = cacheable && !core_write && look_hit;
        go_bus = !iso_load && !iso_store && !hit_read;
    end

    // ==========================================================
    // array write port
    always_comb begin
        last_beat = !r_line_q || (beat_q == cisc_pkg::LINE_LAST_BEAT);
        w_en = 1'b0;
        w_iarr = r_iarr_q;
        w_waddr = {r_addr_q[31:4], beat_q};
        w_data = biu_rdata;
        w_be = cisc_pkg::BE_WORD;
        w_valid = last_beat;
        if (!r_line_q) begin
            w_waddr = r_addr_q[31:2];
        end
        if (state_q == ST_IDLE) begin
            w_iarr = use_iarr;
            w_waddr = core_addr[31:2];
            w_data = core_wdata;
            w_be = core_be;
            w_valid = 1'b1;
            w_en = accept && cacheable && core_write;
            if (core_size != cisc_pkg::SZ_WORD && (iso_q || !look_hit)) begin
                // partial store while isolated or on a miss invalidates the line
                w_be = 4'h0;
                w_valid = 1'b0;
            end
        end else if (r_fill_q) begin
            // line valid set only with its last word
            w_en = biu_done;
        end
    end

    // ==========================================================
    // sequencing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else if (state_q == ST_IDLE) begin
            if (accept && go_bus) begin
                state_q <= ST_BUS;
            end
        end else if (biu_done && (last_beat || !r_fill_q)) begin
            state_q <= ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_addr_q <= 32'h0000_0000;
            r_write_q <= 1'b0;
            r_wdata_q <= 32'h0000_0000;
            r_be_q <= 4'h0;
            r_fill_q <= 1'b0;
            r_line_q <= 1'b0;
            r_iarr_q <= 1'b0;
        end else if (accept) begin
            r_addr_q <= core_addr;
            r_write_q <= core_write;
            r_wdata_q <= core_wdata;
            r_be_q <= core_be;
            r_fill_q <= cacheable && !core_write;
            r_line_q <= use_iarr && cacheable && !core_write;
            r_iarr_q <= use_iarr;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || accept) begin
            beat_q <= 2'h0;
        end else if (state_q == ST_BUS && biu_done) begin
            beat_q <= beat_q + 2'h1;
        end
    end

    // ==========================================================
    // core answer
    always_comb begin
        want_beat = !r_line_q || (beat_q == r_addr_q[3:2]);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rsp_valid_q <= 1'b0;
            if (accept && !go_bus) begin
                rsp_valid_q <= 1'b1;
                // isolated load returns the cache word
                if (!core_write) begin
                    rdata_q <= look_data;
                end
            end else if (state_q == ST_BUS && biu_done) begin
                if (!r_write_q && want_beat) begin
                    rdata_q <= biu_rdata;
                end
                rsp_valid_q <= last_beat || !r_fill_q;
            end
        end
    end

    // ==========================================================
    // bus side
    always_comb begin
        biu_req = (state_q == ST_BUS);
        biu_write = r_write_q;
        biu_wdata = r_wdata_q;
        biu_be = r_write_q ? r_be_q : cisc_pkg::BE_WORD;
        biu_addr = r_line_q ? {r_addr_q[31:4], beat_q, 2'h0} : {r_addr_q[31:2], 2'h0};
    end

    // ==========================================================
    // mode and status registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            iso_q <= cisc_pkg::ISO_RST;
            swap_q <= cisc_pkg::SWAP_RST;
        end else if (reg_wr && reg_addr == cisc_pkg::STATUS_OFS) begin
            iso_q <= reg_wdata[cisc_pkg::STAT_ISO_BIT];
            swap_q <= reg_wdata[cisc_pkg::STAT_SWAP_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alt_q <= cisc_pkg::ALT_RST;
        end else if (reg_wr && reg_addr == cisc_pkg::CONFIG_OFS) begin
            alt_q <= reg_wdata[cisc_pkg::CFG_ALT_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            miss_q <= cisc_pkg::MISS_RST;
        end else if (accept && iso_load) begin
            // miss flag from isolated tag compare
            miss_q <= !look_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata_q <= 32'h0000_0000;
            if (reg_addr == cisc_pkg::STATUS_OFS) begin
                reg_rdata_q[cisc_pkg::STAT_ISO_BIT] <= iso_q;
                reg_rdata_q[cisc_pkg::STAT_SWAP_BIT] <= swap_q;
                reg_rdata_q[cisc_pkg::STAT_MISS_BIT] <= miss_q;
            end else if (reg_addr == cisc_pkg::CONFIG_OFS) begin
                reg_rdata_q[cisc_pkg::CFG_ALT_BIT] <= alt_q;
            end
        end
    end

    always_comb begin
        reg_rdata = reg_rdata_q;
        core_rsp_valid = rsp_valid_q;
        core_rdata = rdata_q;
    end
endmodule

// [bench/cisc_ctrl_properties.sv]
// checker for cisc_ctrl
// assumes binding into cisc_ctrl; sees its ports only
`timescale 1ns/100ps
module cisc_chk (
    input wire logic clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic [7:0] reg_addr, // register address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [31:0] reg_rdata, // read data
    input wire logic core_req, // core request
    input wire logic core_write, // store
    input wire logic core_fetch, // fetch
    input wire logic [31:0] core_addr, // reference address
    input wire logic core_ready, // request taken
    input wire logic core_rsp_valid, // completion
    input wire logic biu_req, // bus pending
    input wire logic biu_write, // bus write
    input wire logic [31:0] biu_addr, // bus address
    input wire logic biu_done // beat done
);
    // ==========================================
    // shadow of mode bits and refill kind
    logic iso_q;
    logic swap_q;
    logic fill_i_q;
    logic take;
    logic cach;
    assign take = core_req && core_ready;
    assign cach = core_addr[31:29] != cisc_pkg::SEG_UNCACHED;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            iso_q <= 1'b0;
            swap_q <= 1'b0;
        end else if (reg_wr && reg_addr == cisc_pkg::STATUS_OFS) begin
            iso_q <= reg_wdata[cisc_pkg::STAT_ISO_BIT];
            swap_q <= reg_wdata[cisc_pkg::STAT_SWAP_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fill_i_q <= 1'b0;
        end else if (take) begin
            fill_i_q <= (core_fetch ^ swap_q) && cach && !core_write;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // properties
    AST_STATUS_FMT: assert property (reg_rd && reg_addr == cisc_pkg::STATUS_OFS |=>
        reg_rdata[31:3] == 29'h0000_0000 && reg_rdata[1:0] == {$past(swap_q), $past(iso_q)})
        else $error("status format");
    AST_UNMAPPED: assert property (reg_rd && reg_addr != cisc_pkg::STATUS_OFS &&
        reg_addr != cisc_pkg::CONFIG_OFS |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped nonzero");
    AST_BYPASS: assert property (take && !cach |=>
        biu_req && biu_addr == {$past(core_addr[31:2]), 2'b00})
        else $error("bypass missed bus");
    AST_ISO_LOCAL: assert property (take && iso_q && cach && !core_fetch |=>
        core_rsp_valid && !biu_req) else $error("isolated used bus");
    AST_WRITE_THRU: assert property (take && core_write && !(iso_q && cach) |=>
        biu_req && biu_write) else $error("no write-through");
    AST_REFUSE: assert property (biu_req |-> !core_ready && !core_rsp_valid)
        else $error("busy overlap");
    AST_LINE_STEP: assert property (biu_req && biu_done && fill_i_q &&
        biu_addr[3:2] != 2'h3 |=> biu_req && biu_addr == $past(biu_addr) + 32'h0000_0004)
        else $error("beat order");
    AST_LINE_END: assert property (biu_req && biu_done &&
        (!fill_i_q || biu_addr[3:2] == 2'h3) |=> core_rsp_valid && !biu_req)
        else $error("bus end");
    AST_HOLD: assert property (biu_req && !biu_done |=>
        biu_req && $stable(biu_addr) && $stable(biu_write)) else $error("bus moved");
endmodule
bind cisc_ctrl cisc_chk i_cisc_chk (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .core_req, .core_write, .core_fetch, .core_addr, .core_ready,
    .core_rsp_valid, .biu_req, .biu_write, .biu_addr, .biu_done);

// [bench/cisc_biu_model.sv]
// bus interface unit model: answers each beat after a settable delay
// assumes requests stand until done; read data derives from the address
`timescale 1ns/100ps
module cisc_biu_model (
    input wire logic clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic [3:0] lat, // cycles to done, at least 1
    input wire logic biu_req, // bus pending
    input wire logic biu_write, // bus write
    input wire logic [31:0] biu_addr, // word address
    input wire logic [31:0] biu_wdata, // write data
    output logic biu_done, // beat finished
    output logic [31:0] biu_rdata, // read beat data
    output int n_rd, // read beats seen
    output int n_wr, // write beats seen
    output logic [31:0] last_wdata // last written word
);
    logic [3:0] cnt_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 4'h0;
            biu_done <= 1'b0;
            biu_rdata <= 32'h0000_0000;
            n_rd <= 0;
            n_wr <= 0;
            last_wdata <= 32'h0000_0000;
        end else if (!biu_req || biu_done || cnt_q + 4'h1 < lat) begin
            // data line toggles while no beat is answered
            cnt_q <= (biu_req && !biu_done) ? cnt_q + 4'h1 : 4'h0;
            biu_done <= 1'b0;
            biu_rdata <= ~biu_rdata;
        end else begin
            cnt_q <= 4'h0;
            biu_done <= 1'b1;
            if (biu_write) begin
                n_wr <= n_wr + 1;
                last_wdata <= biu_wdata;
                biu_rdata <= ~biu_rdata;
            end else begin
                n_rd <= n_rd + 1;
                biu_rdata <= {biu_addr[15:0], ~biu_addr[15:0]};
            end
        end
    end
endmodule

// [bench/cisc_ctrl_tb.sv]
// self-checking bench for cisc_ctrl
// assumes the bus model and the bound checker are built alongside
`timescale 1ns/100ps
module cisc_ctrl_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic core_req = 1'b0;
    logic core_write = 1'b0;
    logic core_fetch = 1'b0;
    logic [1:0] core_size = 2'h0;
    logic [31:0] core_addr = 32'h0000_0000;
    logic [31:0] core_wdata = 32'h0000_0000;
    logic [3:0] lat = 4'h1;
    logic [31:0] reg_rdata, core_rdata, biu_addr, biu_wdata, biu_rdata, last_wdata;
    logic core_ready, core_rsp_valid, biu_req, biu_write, biu_done;
    logic [3:0] biu_be;
    int n_rd, n_wr;
    int err_count = 0;
    int n_compared = 0;
    localparam logic [1:0] WORD = cisc_pkg::SZ_WORD;
    always #5 clk = ~clk;
    cisc_ctrl i_cisc_ctrl (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .core_req, .core_write, .core_fetch, .core_size, .core_addr, .core_wdata, .core_ready,
        .core_rsp_valid, .core_rdata, .biu_req, .biu_write, .biu_addr, .biu_wdata, .biu_be,
        .biu_done, .biu_rdata);
    cisc_biu_model i_cisc_biu_model (.clk, .sys_rst, .lat, .biu_req, .biu_write, .biu_addr,
        .biu_wdata, .biu_done, .biu_rdata, .n_rd, .n_wr, .last_wdata);
    // ==========================================
    // helpers
    function logic [31:0] mem(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    task conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task chk(input string what, input logic [31:0] e, got);
        n_compared++;
        if (got !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, e, got);
        end
    endtask
    task reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(what, e, reg_rdata);
        @(posedge clk);
    endtask
    // one reference: load data, bus beats and, when no beat is expected, answer delay compared
    task op(input string what, input logic w, f, input logic [1:0] sz,
        input logic [31:0] a, d, e, input int er, ew);
        int r0, w0, n;
        r0 = n_rd;
        w0 = n_wr;
        n = 0;
        core_req <= 1'b1;
        core_write <= w;
        core_fetch <= f;
        core_size <= sz;
        core_addr <= a;
        core_wdata <= d;
        @(negedge clk);
        while (core_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        core_req <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (core_rsp_valid !== 1'b1 && n < 100);
        if (!w) chk({what, " data"}, e, core_rdata);
        chk({what, " rd"}, er, n_rd - r0);
        chk({what, " wr"}, ew, n_wr - w0);
        if (er + ew == 0) chk({what, " delay"}, 1, n);
        @(posedge clk);
    endtask
    // ==========================================
    // tests
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk("status reset", cisc_pkg::STATUS_OFS, 32'h0000_0000);
        rd_chk("config reset", cisc_pkg::CONFIG_OFS, 32'h0000_0000);
        reg_wr_t(8'h08, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h08, 32'h0000_0000);
        reg_wr_t(cisc_pkg::STATUS_OFS, 32'h0000_0004);
        rd_chk("miss ro", cisc_pkg::STATUS_OFS, 32'h0000_0000);
        op("unc load", 0, 0, WORD, 32'hA000_0010, 0, mem(32'hA000_0010), 1, 0);
        op("unc store", 1, 0, WORD, 32'hA000_0014, 32'hCAFE_0001, 0, 0, 1);
        chk("unc wdata", 32'hCAFE_0001, last_wdata);
        op("d miss", 0, 0, WORD, 32'h8000_0100, 0, mem(32'h8000_0100), 1, 0);
        op("d hit", 0, 0, WORD, 32'h8000_0100, 0, mem(32'h8000_0100), 0, 0);
        op("wt store", 1, 0, WORD, 32'h8000_0100, 32'h1357_9BDF, 0, 0, 1);
        chk("wt wdata", 32'h1357_9BDF, last_wdata);
        op("half st", 1, 0, cisc_pkg::SZ_HALF, 32'h8000_0102, 32'hABCD_0000, 0, 0, 1);
        chk("half be", 32'h0000_000C, biu_be);
        op("d upd", 0, 0, WORD, 32'h8000_0100, 0, 32'hABCD_9BDF, 0, 0);
        lat <= 4'h3;
        op("i miss", 0, 1, WORD, 32'h8000_0204, 0, mem(32'h8000_0204), 4, 0);
        op("i hit", 0, 1, WORD, 32'h8000_020C, 0, mem(32'h8000_020C), 0, 0);
        reg_wr_t(cisc_pkg::STATUS_OFS, 32'h0000_0001);
        op("iso st", 1, 0, WORD, 32'h8000_0100, 32'h2468_ACE0, 0, 0, 0);
        op("iso ld", 0, 0, WORD, 32'h8000_0100, 0, 32'h2468_ACE0, 0, 0);
        rd_chk("iso hit", cisc_pkg::STATUS_OFS, 32'h0000_0001);
        op("iso miss", 0, 0, WORD, 32'h8000_1100, 0, 32'h2468_ACE0, 0, 0);
        rd_chk("miss flag", cisc_pkg::STATUS_OFS, 32'h0000_0005);
        op("iso ld2", 0, 0, WORD, 32'h8000_0100, 0, 32'h2468_ACE0, 0, 0);
        rd_chk("iso hit2", cisc_pkg::STATUS_OFS, 32'h0000_0001);
        op("iso byte", 1, 0, cisc_pkg::SZ_BYTE, 32'h8000_0100, 32'h0000_00FF, 0, 0, 0);
        op("iso inval", 0, 0, WORD, 32'h8000_0100, 0, 32'h2468_ACE0, 0, 0);
        rd_chk("inval flag", cisc_pkg::STATUS_OFS, 32'h0000_0005);
        reg_wr_t(cisc_pkg::STATUS_OFS, 32'h0000_0000);
        op("refill", 0, 0, WORD, 32'h8000_0100, 0, mem(32'h8000_0100), 1, 0);
        reg_wr_t(cisc_pkg::STATUS_OFS, 32'h0000_0002);
        op("swap d", 0, 0, WORD, 32'h8000_0204, 0, mem(32'h8000_0204), 0, 0);
        op("swap i", 0, 1, WORD, 32'h8000_0100, 0, mem(32'h8000_0100), 0, 0);
        reg_wr_t(cisc_pkg::STATUS_OFS, 32'h0000_0003);
        op("i flush", 1, 0, cisc_pkg::SZ_BYTE, 32'h8000_0200, 32'h0000_0011, 0, 0, 0);
        reg_wr_t(cisc_pkg::STATUS_OFS, 32'h0000_0000);
        op("i refill", 0, 1, WORD, 32'h8000_0208, 0, mem(32'h8000_0208), 4, 0);
        lat <= 4'h1;
        reg_wr_t(cisc_pkg::CONFIG_OFS, 32'h0000_0001);
        rd_chk("config alt", cisc_pkg::CONFIG_OFS, 32'h0000_0001);
        op("alt a", 0, 0, WORD, 32'h8000_2000, 0, mem(32'h8000_2000), 1, 0);
        op("alt b", 0, 0, WORD, 32'h8000_3000, 0, mem(32'h8000_3000), 1, 0);
        op("alt a2", 0, 0, WORD, 32'h8000_2000, 0, mem(32'h8000_2000), 0, 0);
        reg_wr_t(cisc_pkg::CONFIG_OFS, 32'h0000_0000);
        op("nrm c", 0, 0, WORD, 32'h8000_4000, 0, mem(32'h8000_4000), 1, 0);
        op("nrm d", 0, 0, WORD, 32'h8000_5000, 0, mem(32'h8000_5000), 1, 0);
        op("nrm c2", 0, 0, WORD, 32'h8000_4000, 0, mem(32'h8000_4000), 1, 0);
        op("top fill", 0, 0, WORD, 32'h8000_0FFC, 0, mem(32'h8000_0FFC), 1, 0);
        reg_wr_t(cisc_pkg::STATUS_OFS, 32'h0000_0001);
        for (int i = 0; i < 1024; i++) begin
            op("flush", 1, 0, cisc_pkg::SZ_BYTE, 32'(i) << 2, 0, 0, 0, 0);
        end
        reg_wr_t(cisc_pkg::STATUS_OFS, 32'h0000_0000);
        op("fl top", 0, 0, WORD, 32'h8000_0FFC, 0, mem(32'h8000_0FFC), 1, 0);
        op("fl low", 0, 0, WORD, 32'h8000_4000, 0, mem(32'h8000_4000), 1, 0);
        conclude();
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule
